/* hw/mtr_task_timer.sv */
// Purpose: Task sequencing, settling pauses and rate/level configuration
// Assumes: Avalon-MM slave on sys_clk, 25 MHz; one access at a time
// Notes:   Counts run on bit strobes; the rules follow
`timescale 1ns/1ps
`include "mtr_consts.svh"

module mtr_task_timer (
  input  wire logic        sys_clk,         // 25 MHz clock
  input  wire logic        rst_n,           // Synchronous reset, active low
  input  wire logic [3:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte enables
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Low for the accepting cycle
  output logic             bitStrobe,       // Bit-time strobe
  output logic             bufferFreeFlag,  // Data buffer free
  output logic             filterInActive,  // Bits entering the filter/de-interleaver
  output logic             filterOutActive, // Same, after the filter delay
  output mtr_pkg::mtr_rx_ctl_s rxCtl        // Level and filter controls
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic       waitReq_r;
  logic       acc;
  logic       wrCfg;
  logic       wrCmd;
  logic       wrMode;
  logic       cmdOk;
  logic [3:0] cmdTask;

  assign avs_waitrequest = waitReq_r;
  assign acc     = (avs_read || avs_write) && !waitReq_r;
  assign wrCfg   = acc && avs_write && avs_byteenable[0] && avs_address == `MTR_OFS_CONFIG;
  assign wrCmd   = acc && avs_write && avs_byteenable[0] && avs_address == `MTR_OFS_COMMAND;
  assign wrMode  = acc && avs_write && avs_byteenable[0] && avs_address == `MTR_OFS_MODE;
  assign cmdTask = avs_writedata[3:0];

  // One wait cycle, then a single accepting cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
    end else begin
      waitReq_r <= !((avs_read || avs_write) && waitReq_r);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  mtr_pkg::mtr_cfg_s cfg_r;
  logic              txMode_r;
  logic              psave_r;
  logic [1:0]        settleCnt_r;
  logic              settling;
  assign settling = settleCnt_r != 2'h0;
  // Config is write-only; accepted even while settling
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= `MTR_CFG_RESET;
    end else if (wrCfg) begin
      cfg_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {txMode_r, psave_r} <= `MTR_MODE_RESET;
    end else if (wrMode) begin
      txMode_r <= avs_writedata[`MTR_MODE_TX_BIT];
      psave_r  <= avs_writedata[`MTR_MODE_PS_BIT];
    end
  end

  // Restart pause on powersave exit or direction change
  logic modeKick;
  assign modeKick = wrMode && ((txMode_r != avs_writedata[`MTR_MODE_TX_BIT])
                    || (psave_r && !avs_writedata[`MTR_MODE_PS_BIT]));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settleCnt_r <= `MTR_SETTLE_BITS;
    end else if (modeKick) begin
      settleCnt_r <= `MTR_SETTLE_BITS;
    end else if (settling && bitStrobe) begin
      settleCnt_r <= settleCnt_r - 2'h1;
    end
  end

  // Task writes during the pause, in powersave or of the wrong direction are dropped
  function automatic logic isTx(input logic [3:0] t);
    isTx = t >= `MTR_TASK_T_HEAD && t <= `MTR_TASK_T_SCRAM;
  endfunction : isTx
  function automatic logic isRx(input logic [3:0] t);
    isRx = t >= `MTR_TASK_R_SEEK && t <= `MTR_TASK_R_ONE;
  endfunction : isRx
  assign cmdOk = wrCmd && !settling && !psave_r;

  // ****************************************
  // Bit strobe
  // ****************************************
  mtr_bit_divider #(
    .BASE_DIV (`MTR_BASE_DIV),
    .CNT_W    (11)
  ) u_div (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .divSel    (cfg_r.clockDivideSelect),
    .xtalRange (cfg_r.xtalRangeSelect),
    .bitTick   (bitStrobe)
  );

  // ****************************************
  // Task timing tables
  // ****************************************
  function automatic logic [7:0] taskLen(input logic [3:0] t);
    case (t)
      `MTR_TASK_T_HEAD:  taskLen = `MTR_LEN_HEAD;
      `MTR_TASK_T_FOUR:  taskLen = `MTR_LEN_FOUR;
      `MTR_TASK_T_BLOCK: taskLen = `MTR_LEN_BLOCK;
      `MTR_TASK_R_SEEK:  taskLen = `MTR_LEN_HEAD;
      `MTR_TASK_R_HEAD:  taskLen = `MTR_LEN_R_HEAD;
      `MTR_TASK_R_BLOCK: taskLen = `MTR_LEN_BLOCK;
      default:           taskLen = `MTR_LEN_ONE;
    endcase
  endfunction : taskLen
  function automatic logic [7:0] freeAt(input logic [3:0] t);
    case (t)
      `MTR_TASK_T_HEAD:  freeAt = `MTR_FREE_T_HEAD;
      `MTR_TASK_T_FOUR:  freeAt = `MTR_FREE_T_FOUR;
      `MTR_TASK_T_BLOCK: freeAt = `MTR_FREE_T_BLOCK;
      default:           freeAt = `MTR_FREE_T_ONE;
    endcase
  endfunction : freeAt

  // ****************************************
  // Task sequencer
  // ****************************************
  mtr_pkg::mtr_state_e state_r;
  logic [3:0]          curTask_r;
  logic [3:0]          pendTask_r;
  logic                pend_r;
  logic [7:0]          bitCnt_r;
  logic                rxFreeDly_r;
  logic                abortAll;
  logic                newTask;
  logic                lastBit;

  assign abortAll = modeKick || (cmdOk && cmdTask == `MTR_TASK_RESET);
  assign newTask  = cmdOk && (txMode_r ? isTx(cmdTask) : isRx(cmdTask));
  assign lastBit  = state_r == mtr_pkg::ST_RUN && bitStrobe
                    && bitCnt_r + 8'h01 == taskLen(curTask_r);
  // One task may wait; one caught on the last strobe starts from idle
  always_ff @(posedge sys_clk) begin
    if (!rst_n || abortAll) begin
      pend_r     <= 1'b0;
      pendTask_r <= `MTR_TASK_NULL;
    end else if (newTask && state_r != mtr_pkg::ST_IDLE) begin
      pend_r     <= 1'b1;
      pendTask_r <= cmdTask;
    end else if (state_r == mtr_pkg::ST_IDLE
                 || (bitStrobe && (lastBit || state_r == mtr_pkg::ST_SCRAM))) begin
      pend_r     <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || abortAll) begin
      state_r   <= mtr_pkg::ST_IDLE;
      curTask_r <= `MTR_TASK_NULL;
      bitCnt_r  <= 8'h00;
    end else begin
      case (state_r)
        mtr_pkg::ST_IDLE: begin
          if (newTask || pend_r) begin
            state_r   <= mtr_pkg::ST_LEAD;
            curTask_r <= newTask ? cmdTask : pendTask_r;
            bitCnt_r  <= 8'h00;
          end
        end
        mtr_pkg::ST_LEAD: begin
          if (bitStrobe) begin
            bitCnt_r <= bitCnt_r + 8'h01;
            if (bitCnt_r + 8'h01 == `MTR_LEAD_BITS) begin
              bitCnt_r <= 8'h00;
              state_r  <= curTask_r == `MTR_TASK_T_SCRAM ? mtr_pkg::ST_SCRAM
                                                           : mtr_pkg::ST_RUN;
            end
          end
        end
        mtr_pkg::ST_RUN: begin
          if (bitStrobe) begin
            bitCnt_r <= bitCnt_r + 8'h01;
            if (lastBit) begin
              bitCnt_r <= 8'h00;
              if (pend_r) begin
                curTask_r <= pendTask_r;
                state_r   <= pendTask_r == `MTR_TASK_T_SCRAM ? mtr_pkg::ST_SCRAM
                                                               : mtr_pkg::ST_RUN;
              end else begin
                state_r   <= mtr_pkg::ST_IDLE;
              end
            end
          end
        end
        mtr_pkg::ST_SCRAM: begin
          // Scrambler output runs until the next task takes over
          if (bitStrobe && pend_r) begin
            curTask_r <= pendTask_r;
            bitCnt_r  <= 8'h00;
            state_r   <= mtr_pkg::ST_RUN;
          end
        end
        default: state_r <= mtr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Buffer-free flag
  // ****************************************
  logic txFreeSet;
  logic freeClr;
  assign txFreeSet = txMode_r && state_r == mtr_pkg::ST_RUN && bitStrobe
                     && bitCnt_r + 8'h01 == freeAt(curTask_r);
  assign freeClr   = newTask && cmdTask != `MTR_TASK_T_SCRAM;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || abortAll) begin
      rxFreeDly_r <= 1'b0;
    end else if (lastBit && !txMode_r) begin
      rxFreeDly_r <= 1'b1;
    end else if (bitStrobe) begin
      rxFreeDly_r <= 1'b0;
    end
  end

  // Hardware set wins over a clearing write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n || abortAll) begin
      bufferFreeFlag <= 1'b1;
    end else if (txFreeSet || (rxFreeDly_r && bitStrobe)) begin
      bufferFreeFlag <= 1'b1;
    end else if (freeClr) begin
      bufferFreeFlag <= 1'b0;
    end
  end

  // ****************************************
  // Filter latency
  // ****************************************
  logic [`MTR_FILTER_BITS-2:0] lpfPipe_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      filterInActive <= 1'b0;
    end else begin
      filterInActive <= state_r == mtr_pkg::ST_RUN || state_r == mtr_pkg::ST_SCRAM;
    end
  end

  // Shifted on bit strobes so the delay tracks the bit rate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lpfPipe_r       <= '0;
      filterOutActive <= 1'b0;
    end else if (bitStrobe) begin
      lpfPipe_r       <= (`MTR_FILTER_BITS-1)'({lpfPipe_r, filterInActive});
      filterOutActive <= lpfPipe_r[`MTR_FILTER_BITS-2];
    end
  end

  // ****************************************
  // Receive level controls
  // ****************************************
  logic [7:0] acqCnt_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || abortAll) begin
      acqCnt_r <= 8'h00;
    end else if (cmdOk && avs_writedata[`MTR_CMD_ACQ_BIT] && !txMode_r) begin
      acqCnt_r <= `MTR_ACQ_BITS;
    end else if (bitStrobe && acqCnt_r != 8'h00) begin
      acqCnt_r <= acqCnt_r - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxCtl <= '0;
    end else begin
      rxCtl.rateFilter    <= cfg_r.rateFilterSelect;
      rxCtl.levelAcquire  <= acqCnt_r != 8'h00;
      rxCtl.levelResponse <= txMode_r ? `MTR_LVL_HOLD : cfg_r.levelResponseSelect;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && waitReq_r) begin // Stands by the accepting edge
      case (avs_address)
        `MTR_OFS_MODE:   avs_readdata <= {30'h0, txMode_r, psave_r};
        `MTR_OFS_STATUS: avs_readdata <= {24'h0, pend_r, settling, state_r,
                                          curTask_r};
        default:         avs_readdata <= 32'h0000_0000; // Config is write-only
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_SETTLE_BLOCKS: assert property (wrCmd && settling && state_r == mtr_pkg::ST_IDLE
    |=> state_r == mtr_pkg::ST_IDLE) else $error("task taken during settling pause");
  AST_CFG_DURING_SETTLE: assert property (wrCfg && settling
    |=> cfg_r == $past(avs_writedata[7:0])) else $error("config write lost while settling");
  AST_LEAD_ONE_BIT: assert property (state_r == mtr_pkg::ST_LEAD && bitStrobe && !abortAll
    |=> state_r != mtr_pkg::ST_LEAD) else $error("lead longer than one bit");
  AST_TX_FREE_TIME: assert property (txFreeSet && !abortAll
    |=> bufferFreeFlag) else $error("buffer free not raised at its bit");
  AST_RUN_BOUND: assert property (state_r == mtr_pkg::ST_RUN
    |-> bitCnt_r < taskLen(curTask_r)) else $error("task ran past its length");
  AST_RX_FREE: assert property (rxFreeDly_r && bitStrobe && !abortAll
    |=> bufferFreeFlag) else $error("receive free late");
  AST_FILTER_DELAY: assert property (bitStrobe
    |=> filterOutActive == $past(lpfPipe_r[`MTR_FILTER_BITS-2])) else $error("filter delay");
  AST_LEVEL_TX: assert property (txMode_r ##1 txMode_r
    |-> rxCtl.levelResponse == `MTR_LVL_HOLD) else $error("level response used in transmit");
  AST_FREE_CLEAR: assert property (freeClr && !txFreeSet && !(rxFreeDly_r && bitStrobe)
    && !abortAll |=> !bufferFreeFlag) else $error("task write left buffer free set");
  COV_TX_GAPLESS: cover property (lastBit && pend_r && txMode_r);
  COV_RX_DONE: cover property (rxFreeDly_r && bitStrobe);
  COV_SETTLE_DROP: cover property (wrCmd && settling);
  COV_SCRAM_HANDOFF: cover property (state_r == mtr_pkg::ST_SCRAM && pend_r && bitStrobe);

endmodule : mtr_task_timer

/* include/mtr_consts.svh */
// Purpose: Offsets, field positions, reset values and bit-time counts
// Assumes: Included by the task timing block and its bit divider
// Notes:   Bit-time counts are in bit strobes, not clock cycles; MTR_BASE_DIV is in clock cycles
`ifndef MTR_CONSTS_SVH
`define MTR_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MTR_OFS_CONFIG    4'h0
`define MTR_OFS_COMMAND   4'h4
`define MTR_OFS_MODE      4'h8
`define MTR_OFS_STATUS    4'hC

// ****************************************
// Field positions and reset values
// ****************************************
`define MTR_CFG_RESET     8'h00
`define MTR_MODE_TX_BIT   1
`define MTR_MODE_PS_BIT   0
`define MTR_MODE_RESET    2'h1
`define MTR_CMD_ACQ_BIT   4
`define MTR_LVL_HOLD      2'h0

// ****************************************
// Task codes (command bits 3:0)
// ****************************************
`define MTR_TASK_NULL     4'h0
`define MTR_TASK_T_HEAD   4'h1
`define MTR_TASK_T_FOUR   4'h2
`define MTR_TASK_T_BLOCK  4'h3
`define MTR_TASK_T_ONE    4'h4
`define MTR_TASK_T_SCRAM  4'h5
`define MTR_TASK_R_SEEK   4'h6
`define MTR_TASK_R_HEAD   4'h7
`define MTR_TASK_R_BLOCK  4'h8
`define MTR_TASK_R_ONE    4'h9
`define MTR_TASK_RESET    4'hF

// ****************************************
// Bit-time counts
// ****************************************
`define MTR_SETTLE_BITS   2'h2
`define MTR_FILTER_BITS   2
`define MTR_LEAD_BITS     8'h01
`define MTR_FREE_T_HEAD   8'h24
`define MTR_FREE_T_FOUR   8'h18
`define MTR_FREE_T_BLOCK  8'h14
`define MTR_FREE_T_ONE    8'h01
`define MTR_LEN_HEAD      8'h38
`define MTR_LEN_FOUR      8'h20
`define MTR_LEN_BLOCK     8'hF0
`define MTR_LEN_ONE       8'h08
`define MTR_LEN_R_HEAD    8'h18
`define MTR_ACQ_BITS      8'h10
`define MTR_BASE_DIV      128

`endif

/* include/mtr_pkg.sv */
// Purpose: Types shared by the task timing block
// Assumes: Constants come from mtr_consts.svh
// Notes:   Field order of mtr_cfg_s matches the config register bits
package mtr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_RUN,
    ST_SCRAM
  } mtr_state_e;

  typedef struct packed {
    logic [1:0] clockDivideSelect;
    logic       xtalRangeSelect;
    logic       rateFilterSelect;
    logic [1:0] levelResponseSelect;
    logic [1:0] spare;
  } mtr_cfg_s;

  typedef struct packed {
    logic [1:0] levelResponse;
    logic       levelAcquire;
    logic       rateFilter;
  } mtr_rx_ctl_s;

endpackage : mtr_pkg

/* hw/mtr_bit_divider.sv */
// Purpose: Bit-time strobe from the crystal clock by a selectable ratio
// Assumes: Select inputs come from registers on the same clock
// Notes:   Ratio is BASE_DIV << (divSel + range)
`timescale 1ns/1ps
`include "mtr_consts.svh"

module mtr_bit_divider #(
  parameter int BASE_DIV = `MTR_BASE_DIV,
  parameter int CNT_W    = 11
) (
  input  wire logic       sys_clk,   // Crystal clock
  input  wire logic       rst_n,     // Synchronous reset, active low
  input  wire logic [1:0] divSel,    // Divide ratio select
  input  wire logic       xtalRange, // High doubles the ratio
  output logic            bitTick    // One-clock strobe per bit time
);

  generate
    if (BASE_DIV < 2 || BASE_DIV * 16 > (1 << CNT_W)) begin : g_chk
      $error("mtr_bit_divider: BASE_DIV does not fit CNT_W");
    end
  endgenerate

  logic [CNT_W-1:0] divCnt_r;
  logic [CNT_W-1:0] divLast;
  logic [2:0]       shift;

  always_comb begin
    shift   = {1'b0, divSel} + {2'b00, xtalRange};
    divLast = CNT_W'((BASE_DIV << shift) - 1);
  end

  // Ratio change restarts cleanly since a count at or above divLast wraps to zero at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      divCnt_r <= '0;
      bitTick  <= 1'b0;
    end else if (divCnt_r >= divLast) begin
      divCnt_r <= '0;
      bitTick  <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
      bitTick  <= 1'b0;
    end
  end

endmodule : mtr_bit_divider

/* sim/mtr_host_model.sv */
// Purpose: Host model issuing Avalon-MM accesses to the task timer
// Assumes: One access at a time; signals change right after a rising edge
// Notes:   Released lines carry inverted data so stale values never match
`timescale 1ns/1ps

module mtr_host_model (
  input  wire logic        sys_clk,         // 25 MHz clock
  input  wire logic        avs_waitrequest, // Slave stall
  input  wire logic [31:0] avs_readdata,    // Read data
  input  wire logic        bitStrobe,       // Bit-time strobe
  output logic [3:0]       avs_address,     // Byte address
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic [31:0]      avs_writedata,   // Write data
  output logic [3:0]       avs_byteenable   // Byte enables
);
  initial begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // Callers pick rates inside the legal band and set bit 4 to suit it
  // Level response codes come from the caller; hold is used only on fades (the timer forces MTR_LVL_HOLD throughout transmit mode instead)
  task automatic busWrite(input logic [3:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    avs_address   <= addr;
    avs_writedata <= {24'h000000, data};
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write     <= 1'b0;
    avs_address   <= ~addr;
    avs_writedata <= ~{24'h000000, data};
  endtask : busWrite

  task automatic busRead(input logic [3:0] addr, output logic [31:0] data);
    @(posedge sys_clk);
    avs_address <= addr;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    data = avs_readdata;
    avs_read    <= 1'b0;
    avs_address <= ~addr;
  endtask : busRead

  // Settling pause before a new task; tasks go in from idle, well outside the
  // next-task windows
  task automatic waitBits(input int n);
    repeat (n) begin
      do @(posedge sys_clk); while (bitStrobe !== 1'b1);
    end
  endtask : waitBits
endmodule : mtr_host_model

/* sim/test_mtr_task_timer.sv */
// Purpose: Self-checking bench for the task timer
// Assumes: Config ratio 128 during task runs keeps the run short
// Notes:   Signals are read at the clock edge, i.e. their pre-edge values
`timescale 1ns/1ps
`include "mtr_consts.svh"

module test_mtr_task_timer;
  logic                 sys_clk;
  logic                 rst_n;
  logic [3:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [3:0]           avs_byteenable;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic                 bitStrobe;
  logic                 bufferFreeFlag;
  logic                 filterInActive;
  logic                 filterOutActive;
  mtr_pkg::mtr_rx_ctl_s rxCtl;
  logic [31:0]          rdData;
  int                   nMismatch;
  int                   checksDone;
  int                   cyc;

  mtr_task_timer mtr_task_timer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bitStrobe(bitStrobe),
    .bufferFreeFlag(bufferFreeFlag), .filterInActive(filterInActive),
    .filterOutActive(filterOutActive), .rxCtl(rxCtl)
  );

  mtr_host_model mtr_host_model_inst (
    .sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .bitStrobe(bitStrobe), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      nMismatch++;
    end
  endtask : check

  task automatic stop_test;
    if (nMismatch == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // One task from idle: lead strobes, strobes to buffer free, bits in flight
  task automatic runTask(input logic [3:0] code, input logic [7:0] expFree,
                         input logic [7:0] expLen);
    int lead, n, len, gotFree, gotOut, guard;
    lead = 0; n = 0; len = 0; gotFree = -1; gotOut = -1; guard = 0;
    mtr_host_model_inst.busWrite(`MTR_OFS_COMMAND, {4'h0, code});
    while (filterInActive !== 1'b1 && guard < 5000) begin
      @(posedge sys_clk);
      guard++;
      if (guard == 2) check({31'h0, bufferFreeFlag}, 32'h0);
      if (bitStrobe === 1'b1 && filterInActive !== 1'b1) lead++;
    end
    while ((filterInActive === 1'b1 || gotFree < 0) && guard < 60000) begin
      if (bitStrobe === 1'b1) begin
        n++;
        if (filterInActive === 1'b1) len++;
      end
      if (bufferFreeFlag === 1'b1 && gotFree < 0) gotFree = n;
      if (filterOutActive === 1'b1 && gotOut < 0) gotOut = n;
      @(posedge sys_clk);
      guard++;
    end
    check(lead, 32'h1);
    check(gotFree, {24'h0, expFree});
    check(len, {24'h0, expLen});
    check(gotOut, 32'h2);
    mtr_host_model_inst.waitBits(3);
  endtask : runTask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (95000) @(posedge sys_clk);
    nMismatch++;
    stop_test();
  end

  initial begin
    nMismatch = 0;
    checksDone = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Leave powersave in receive mode; status reads work but a task write is dropped meanwhile
    mtr_host_model_inst.busWrite(`MTR_OFS_MODE, 8'h00);
    mtr_host_model_inst.busRead(`MTR_OFS_STATUS, rdData);
    check({31'h0, rdData[6]}, 32'h1);
    mtr_host_model_inst.busWrite(`MTR_OFS_COMMAND, 8'h06);
    repeat (2) @(posedge sys_clk);
    check({31'h0, bufferFreeFlag}, 32'h1);
    mtr_host_model_inst.waitBits(3);
    mtr_host_model_inst.busRead(`MTR_OFS_STATUS, rdData);
    check({31'h0, rdData[6]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mtr_host_model_inst.busWrite(`MTR_OFS_CONFIG, {3'h0, i[0], i[1:0], 2'h0});
      repeat (2) @(posedge sys_clk);
      check({30'h0, rxCtl.levelResponse}, i);
      check({31'h0, rxCtl.rateFilter}, {31'h0, i[0]});
    end
    mtr_host_model_inst.busWrite(`MTR_OFS_CONFIG, 8'h04);
    mtr_host_model_inst.busRead(`MTR_OFS_CONFIG, rdData);
    check(rdData, 32'h0);
    mtr_host_model_inst.busWrite(`MTR_OFS_COMMAND, 8'h10);
    repeat (2) @(posedge sys_clk);
    check({31'h0, rxCtl.levelAcquire}, 32'h1);
    check({31'h0, bufferFreeFlag}, 32'h1);
    mtr_host_model_inst.waitBits(2);
    runTask(4'h6, 8'h39, 8'h38);
    runTask(4'h7, 8'h19, 8'h18);
    runTask(4'h9, 8'h09, 8'h08);
    // Every divide code with both crystal ranges
    for (int c = 0; c < 8; c++) begin
      mtr_host_model_inst.busWrite(`MTR_OFS_CONFIG, {c[1:0], c[2], 5'h04});
      mtr_host_model_inst.waitBits(2);
      cyc = 0;
      do begin
        @(posedge sys_clk);
        cyc++;
      end while (bitStrobe !== 1'b1);
      check(cyc, (32'h80 << c[2]) << c[1:0]);
    end
    mtr_host_model_inst.busWrite(`MTR_OFS_MODE, 8'h02);
    // Config write inside the settling pause must still land
    mtr_host_model_inst.busWrite(`MTR_OFS_CONFIG, 8'h14);
    mtr_host_model_inst.busRead(`MTR_OFS_STATUS, rdData);
    check({31'h0, rdData[6]}, 32'h1);
    mtr_host_model_inst.waitBits(3);
    check({31'h0, rxCtl.rateFilter}, 32'h1);
    check({30'h0, rxCtl.levelResponse}, 32'h0);
    runTask(4'h1, 8'h24, 8'h38);
    runTask(4'h2, 8'h18, 8'h20);
    runTask(4'h3, 8'h14, 8'hF0);
    runTask(4'h4, 8'h01, 8'h08);
    stop_test();
  end
endmodule : test_mtr_task_timer
